/* File: core/srac_decoder.sv */
// module: serial command decoder, register read-back and primary setup register
`timescale 1ns/10ps

// Summary of operation
// - every access frame is exactly 16 serial clocks carrying one command word.
// - bit 15 is the write flag, bits 14..12 are the register select.
// - write flag 1 with valid writable select loads the 12 data bits.
// - write flag 0 with valid select returns that register on next frame.
// - read of select 0, 6 or 7 is ignored; next frame returns conversion results.
// - data bits stored only on write with select 1, 2 or 5; otherwise nothing changes.
// - bit 11 channel pair select: 0 first inputs, 1 second inputs.
// - bit 10 alternation enable: 1 cycles between the two inputs.
// - bit 9 averaging style: 0 normal block, 1 rolling.
// - bits 8..6 averaging ratio: 000 off, 001 2x, 010 4x, 011 8x.
// - normal supports up to 32x, rolling only up to 8x.
// - top nibble is the address; all setup fields reset to zero.
// - writes to read-only registers are discarded.
module srac_decoder
    import srac_pkg::*;
#(
    parameter logic [11:0] SETUP2_RST   = 12'h000,
    parameter logic [11:0] ALERT_LO_RST = 12'h800,
    parameter logic [11:0] ALERT_HI_RST = 12'h7ff
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              sclk,
    input  wire logic              cs_n,
    input  wire logic              serial_command_in,
    input  wire logic [15:0]       conversion_word,
    input  wire logic [11:0]       alert_status,
    output logic                   primary_serial_out,
    output logic                   frame_done,
    output srac_pkg::srac_cmd_t    last_cmd,
    output srac_pkg::srac_cfg_t    setup_cfg
);
    import srac_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pins_s;
    srac_sync #(.WIDTH(3)) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        // select goes in inverted so a flushed synchroniser reads as idle
        .d       ({sclk, ~cs_n, serial_command_in}),
        .q       (pins_s)
    );

    logic sclk_s;
    logic cs_n_s;
    logic cmd_in_s;
    assign sclk_s   = pins_s[2];
    assign cs_n_s   = ~pins_s[1];
    assign cmd_in_s = pins_s[0];

    // ****************************************
    // state
    // ****************************************
    logic        sclk_d_r;
    logic [4:0]  bit_cnt_r;
    logic [15:0] shift_in_r;
    logic [15:0] shift_out_r;
    logic [2:0]  rd_sel_r;
    logic        rd_pend_r;
    logic        done_r;
    srac_cmd_t   cmd_r;
    logic [11:0] setup1_r;
    logic [11:0] setup2_r;
    logic [11:0] alert_lo_r;
    logic [11:0] alert_hi_r;
    logic        cs_active_r;

    logic        sclk_d_nxt;
    logic [4:0]  bit_cnt_nxt;
    logic [15:0] shift_in_nxt;
    logic [15:0] shift_out_nxt;
    logic [2:0]  rd_sel_nxt;
    logic        rd_pend_nxt;
    logic        done_nxt;
    srac_cmd_t   cmd_nxt;
    logic [11:0] setup1_nxt;
    logic [11:0] setup2_nxt;
    logic [11:0] alert_lo_nxt;
    logic [11:0] alert_hi_nxt;
    logic        cs_active_nxt;

    logic        rise;
    logic        fall;
    logic        frame_start;
    logic        frame_end;
    logic [15:0] rx_word;
    srac_cmd_t   rx_cmd;
    logic [15:0] rd_word;
    logic [15:0] load_word;

    // edges found by sampling the link clock
    assign rise        = sclk_s & ~sclk_d_r;
    assign fall        = ~sclk_s & sclk_d_r;
    assign frame_start = cs_n_s == 1'b0 && bit_cnt_r == 5'h0 && !cs_active_r;
    // word taken msb first on rising edges
    assign rx_word     = {shift_in_r[14:0], cmd_in_s};
    assign rx_cmd      = srac_cmd_t'(rx_word);
    assign frame_end   = rise && !cs_n_s && bit_cnt_r == 5'(FRAME_BITS - 1);

    // ****************************************
    // read-back word selection
    // ****************************************
    always_comb begin
        unique case (rd_sel_r)
            // top nibble is the address nibble, write flag position zero
            SEL_SETUP1:   rd_word = {1'b0, SEL_SETUP1, setup1_r};
            SEL_SETUP2:   rd_word = {1'b0, SEL_SETUP2, setup2_r};
            SEL_ALERT:    rd_word = {1'b0, SEL_ALERT, alert_status};
            SEL_ALERT_LO: rd_word = {1'b0, SEL_ALERT_LO, alert_lo_r};
            SEL_ALERT_HI: rd_word = {1'b0, SEL_ALERT_HI, alert_hi_r};
            default:      rd_word = conversion_word;
        endcase
        // a pending read replaces conversion data for one frame only
        load_word = rd_pend_r ? rd_word : conversion_word;
    end

    // ****************************************
    // frame engine
    // ****************************************
    always_comb begin
        sclk_d_nxt    = sclk_s;
        bit_cnt_nxt   = bit_cnt_r;
        shift_in_nxt  = shift_in_r;
        shift_out_nxt = shift_out_r;
        rd_sel_nxt    = rd_sel_r;
        rd_pend_nxt   = rd_pend_r;
        done_nxt      = 1'b0;
        cmd_nxt       = cmd_r;
        cs_active_nxt = !cs_n_s;
        setup1_nxt    = setup1_r;
        setup2_nxt    = setup2_r;
        alert_lo_nxt  = alert_lo_r;
        alert_hi_nxt  = alert_hi_r;
        if (cs_n_s) begin
            // partial frame aborted: nothing is committed
            bit_cnt_nxt = 5'h0;
        end else begin
            if (frame_start) begin
                shift_out_nxt = load_word;
                rd_pend_nxt   = 1'b0;
            end
            if (rise && bit_cnt_r < 5'(FRAME_BITS)) begin
                shift_in_nxt = rx_word;
                bit_cnt_nxt  = bit_cnt_r + 5'h1;
            end
            if (fall && bit_cnt_r != 5'h0) begin
                shift_out_nxt = {shift_out_r[14:0], 1'b0};
            end
        end
        if (frame_end) begin
            done_nxt = 1'b1;
            cmd_nxt  = rx_cmd;
            if (rx_cmd.write_flag) begin
                // only the setup registers and the upper threshold take writes
                unique case (rx_cmd.register_select)
                    SEL_SETUP1:   setup1_nxt   = rx_cmd.data;
                    SEL_SETUP2:   setup2_nxt   = rx_cmd.data;
                    SEL_ALERT_HI: alert_hi_nxt = rx_cmd.data;
                    default:      ;
                endcase
            end else begin
                rd_sel_nxt  = rx_cmd.register_select;
                // nop selects leave conversion output on the next frame
                rd_pend_nxt = !(rx_cmd.register_select == SEL_NOP0 ||
                                rx_cmd.register_select == SEL_NOP6 ||
                                rx_cmd.register_select == SEL_NOP7);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_d_r    <= 1'b0;
            bit_cnt_r   <= 5'h0;
            shift_in_r  <= 16'h0000;
            shift_out_r <= 16'h0000;
            rd_sel_r    <= SEL_NOP0;
            rd_pend_r   <= 1'b0;
            done_r      <= 1'b0;
            cmd_r       <= '0;
            cs_active_r <= 1'b0;
            setup1_r    <= SETUP1_RST;
            setup2_r    <= SETUP2_RST;
            alert_lo_r  <= ALERT_LO_RST;
            alert_hi_r  <= ALERT_HI_RST;
        end else begin
            sclk_d_r    <= sclk_d_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            shift_in_r  <= shift_in_nxt;
            shift_out_r <= shift_out_nxt;
            rd_sel_r    <= rd_sel_nxt;
            rd_pend_r   <= rd_pend_nxt;
            done_r      <= done_nxt;
            cmd_r       <= cmd_nxt;
            cs_active_r <= cs_active_nxt;
            setup1_r    <= setup1_nxt;
            setup2_r    <= setup2_nxt;
            alert_lo_r  <= alert_lo_nxt;
            alert_hi_r  <= alert_hi_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        setup_cfg.channel_pair_select      = setup1_r[PAIR_POS];
        setup_cfg.input_alternation_enable = setup1_r[ALT_POS];
        setup_cfg.averaging_style          = setup1_r[STYLE_POS];
        setup_cfg.averaging_ratio          = setup1_r[RATIO_MSB:RATIO_LSB];
        // unsupported ratio for the chosen style means no averaging
        if (setup1_r[STYLE_POS] ? setup1_r[RATIO_MSB:RATIO_LSB] > RATIO_X8
                                : setup1_r[RATIO_MSB:RATIO_LSB] > RATIO_X32) begin
            setup_cfg.effective_ratio = RATIO_OFF;
        end else begin
            setup_cfg.effective_ratio = setup1_r[RATIO_MSB:RATIO_LSB];
        end
    end

    assign primary_serial_out = shift_out_r[15];
    assign frame_done         = done_r;
    assign last_cmd           = cmd_r;
endmodule

/* File: core/srac_pkg.sv */
// package: constants and types for the serial register access decoder
package srac_pkg;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int unsigned FRAME_BITS    = 16;
    localparam int unsigned WR_BIT        = 15;
    localparam int unsigned SEL_MSB       = 14;
    localparam int unsigned SEL_LSB       = 12;
    localparam int unsigned DATA_MSB      = 11;

    // ****************************************
    // register selects
    // ****************************************
    localparam logic [2:0] SEL_NOP0       = 3'h0;
    localparam logic [2:0] SEL_SETUP1     = 3'h1;
    localparam logic [2:0] SEL_SETUP2     = 3'h2;
    localparam logic [2:0] SEL_ALERT      = 3'h3;
    localparam logic [2:0] SEL_ALERT_LO   = 3'h4;
    localparam logic [2:0] SEL_ALERT_HI   = 3'h5;
    localparam logic [2:0] SEL_NOP6       = 3'h6;
    localparam logic [2:0] SEL_NOP7       = 3'h7;

    // ****************************************
    // primary setup register fields
    // ****************************************
    localparam int unsigned PAIR_POS      = 11;
    localparam int unsigned ALT_POS       = 10;
    localparam int unsigned STYLE_POS     = 9;
    localparam int unsigned RATIO_MSB     = 8;
    localparam int unsigned RATIO_LSB     = 6;
    localparam logic [11:0] SETUP1_RST    = 12'h000;

    localparam logic [2:0] RATIO_OFF      = 3'h0;
    localparam logic [2:0] RATIO_X8       = 3'h3;
    localparam logic [2:0] RATIO_X32      = 3'h5;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       write_flag;
        logic [2:0] register_select;
        logic [11:0] data;
    } srac_cmd_t;

    typedef struct packed {
        logic       channel_pair_select;
        logic       input_alternation_enable;
        logic       averaging_style;
        logic [2:0] averaging_ratio;
        logic [2:0] effective_ratio;
    } srac_cfg_t;

endpackage

/* File: core/srac_sync.sv */
// module: two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module srac_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

/* File: dv/srac_asserts.sv */
// checker: port assertions for the serial register decoder
`timescale 1ns/10ps
module srac_asserts
    import srac_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                sclk,
    input wire logic                cs_n,
    input wire logic                serial_command_in,
    input wire logic [15:0]         conversion_word,
    input wire logic [11:0]         alert_status,
    input wire logic                primary_serial_out,
    input wire logic                frame_done,
    input wire srac_pkg::srac_cmd_t last_cmd,
    input wire srac_pkg::srac_cfg_t setup_cfg
);
    // ****************************************
    // helpers and properties
    // ****************************************
    logic done_d_r;
    always_ff @(posedge clk_sys) begin
        done_d_r <= frame_done;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_done_spacing: assert property (frame_done |=> !frame_done [*8])
        else $error("frame done pulses too close");
    a_reset_clear: assert property ($rose(rst_n) |-> !primary_serial_out
        && last_cmd == 16'h0 && setup_cfg == 9'h0) else $error("outputs not cleared");
    a_cfg_write: assert property (frame_done && last_cmd.write_flag
        && last_cmd.register_select == SEL_SETUP1 |-> ##[0:1]
        setup_cfg[8:3] == last_cmd.data[11:6]) else $error("setup write lost");
    a_cfg_hold: assert property (frame_done && !(last_cmd.write_flag
        && last_cmd.register_select == SEL_SETUP1) |=> $stable(setup_cfg))
        else $error("setup changed without write");
    a_cfg_cause: assert property ($changed(setup_cfg) |-> frame_done || done_d_r)
        else $error("setup changed outside frame end");
    a_eff_ratio: assert property (setup_cfg.effective_ratio ==
        ((setup_cfg.averaging_style ? setup_cfg.averaging_ratio > RATIO_X8
        : setup_cfg.averaging_ratio > RATIO_X32) ? RATIO_OFF : setup_cfg.averaging_ratio))
        else $error("effective ratio wrong");
    a_rolling_cap: assert property (setup_cfg.averaging_style
        |-> setup_cfg.effective_ratio <= RATIO_X8) else $error("rolling ratio too high");
    a_cmd_hold: assert property (frame_done |-> ##2 $stable(last_cmd) [*6])
        else $error("command changed between frames");
endmodule

/* File: dv/srac_host.sv */
// host model: shifts command frames in and captures the output word
`timescale 1ns/10ps
module srac_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_command_in,
    input  wire logic sout
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_command_in = 1'b0;
    end
    // ****************************************
    // one frame; n below 16 aborts it
    // ****************************************
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0;
        cs_n = 1'b0;
        #80;
        for (int i = 15; i > 15 - n; i--) begin
            serial_command_in = w[i];
            #40 sclk = 1'b1;
            #40 r[i] = sout;
            sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        serial_command_in = ~serial_command_in; // line flipped to the inverse of the last bit, no stale value
        #80;
    endtask
endmodule

/* File: dv/test_serial_register_access_config.sv */
// testbench: corner and random frames against the decoder
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_serial_register_access_config;
    import srac_pkg::*;
    logic        clk_sys, rst_n, sclk, cs_n, cmd_in, sout, frame_done;
    logic [15:0] conv, r, exp_r;
    logic [11:0] alert;
    logic [11:0] regs [8];
    srac_cmd_t   last_cmd;
    srac_cfg_t   setup_cfg;
    int          fails = 0, tests_run = 0, ndone = 0, seed = 32'h18b8afde;

    srac_decoder u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .serial_command_in(cmd_in), .conversion_word(conv), .alert_status(alert),
        .primary_serial_out(sout), .frame_done(frame_done), .last_cmd(last_cmd),
        .setup_cfg(setup_cfg));
    srac_host u_host (.sclk(sclk), .cs_n(cs_n), .serial_command_in(cmd_in), .sout(sout));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (frame_done === 1'b1) ndone++;

    function automatic logic [2:0] eff(logic s, logic [2:0] q);
        return (s ? q > 3'h3 : q > 3'h5) ? 3'h0 : q;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // one frame with its expectations
    // ****************************************
    task automatic frame(input logic [15:0] cw, input int n);
        int d0;
        logic [2:0] s;
        d0 = ndone;
        s = cw[14:12];
        u_host.xfer(cw, n, r);
        if (n < 16) begin
            `CHK(ndone, d0)
            return;
        end
        `CHK(ndone, d0 + 1)
        `CHK(r, exp_r)
        `CHK(last_cmd, cw)
        @(negedge clk_sys);
        conv = $random(seed);
        alert = $random(seed);
        exp_r = conv;
        if (cw[15] && s inside {SEL_SETUP1, SEL_SETUP2, SEL_ALERT_HI}) regs[s] = cw[11:0];
        else if (!cw[15] && !(s inside {SEL_NOP0, SEL_NOP6, SEL_NOP7}))
            exp_r = {1'b0, s, s == SEL_ALERT ? alert : regs[s]};
        `CHK(setup_cfg, {regs[1][11:6], eff(regs[1][9], regs[1][8:6])})
    endtask

    initial begin
        rst_n = 1'b0;
        conv = $random(seed);
        alert = $random(seed);
        regs = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h800, 12'h7ff, 12'h0, 12'h0};
        exp_r = conv;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(setup_cfg, 9'h0)
        frame(16'hffff, 8);
        `CHK(last_cmd, 16'h0)
        for (int i = 0; i < 16; i++) frame({4'h9, 2'(i), i[3], i[2:0], 6'h15}, 16);
        for (int s = 0; s < 8; s++) begin
            frame({1'b1, 3'(s), 12'($random(seed))}, 16);
            frame({1'b0, 3'(s), 12'($random(seed))}, 16);
        end
        // mid-run reset: fields back to defaults, last command cleared
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        regs = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h800, 12'h7ff, 12'h0, 12'h0};
        exp_r = conv;
        repeat (3) @(negedge clk_sys);
        `CHK(setup_cfg, 9'h0)
        `CHK(last_cmd, 16'h0)
        frame(16'h1a40, 16);
        frame(16'h1000, 16);
        for (int i = 0; i < 40; i++) frame(16'($random(seed)), 16);
        frame(16'h0, 16);
        stop_test();
    end
endmodule

bind srac_decoder srac_asserts u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
    .cs_n(cs_n), .serial_command_in(serial_command_in), .conversion_word(conversion_word),
    .alert_status(alert_status), .primary_serial_out(primary_serial_out),
    .frame_done(frame_done), .last_cmd(last_cmd), .setup_cfg(setup_cfg));
